// [tmw_pkg.sv]
// Purpose: shared constants for the 8-bit timer waveform block
// Assumes: 8-bit counter, two compare channels, register port with 4-bit address
// Notes: register offsets and layouts are local to this block
package tmw_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;   // [7:6] mode a, [5:4] mode b, [2:0] waveform
    localparam logic [3:0] REG_FORCE = 4'h1;  // [1] force a, [0] force b (write only)
    localparam logic [3:0] REG_COUNT = 4'h2;
    localparam logic [3:0] REG_CMPA = 4'h3;
    localparam logic [3:0] REG_CMPB = 4'h4;
    localparam logic [3:0] REG_FLAGS = 4'h5;  // [2] cmp b, [1] cmp a, [0] overflow; w1c
    localparam logic [3:0] REG_STATE = 4'h6;  // [1] state a, [0] state b (read only)
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_MODE_A_LSB = 6;
    localparam int CTRL_MODE_B_LSB = 4;
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_CMPA_BIT = 1;
    localparam int FLAG_CMPB_BIT = 2;
    localparam int FORCE_A_BIT = 1;
    localparam int FORCE_B_BIT = 0;
    // ----------------------------------------------------------------
    // values and encodings
    // ----------------------------------------------------------------
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] WGM_NORMAL = 3'h0;
    localparam logic [2:0] WGM_CLEAR_ON_MATCH = 3'h2;
    localparam logic [2:0] WGM_FAST_MAX = 3'h3;
    localparam logic [2:0] WGM_FAST_CMPA = 3'h7;
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
endpackage : tmw_pkg

// [tmw_port_model.sv]
// Purpose: behavioural port pad that the timer block drives
// Assumes: pad has a pull-up, driver on while enable_n is low
// Notes: undriven pad reads the pull-up level, never the last driven value
`timescale 1ns/1ns
module tmw_port_model (
    input wire logic pinOut,
    input wire logic pinOutEn_n,
    output logic padLevel
);
    // pad resolves driver against the pull-up
    assign padLevel = pinOutEn_n ? 1'b1 : pinOut;
endmodule : tmw_port_model

// [tmw_timer8_waveform_modes.sv]
// Purpose: counter, compare, flag and output-state logic of an 8-bit timer
// Assumes: timerTick is a one-cycle prescaled enable from the same clock
// Notes: phase correct encodings are left to a separate unit; this block idles there
`timescale 1ns/1ns

module tmw_timer8_waveform_modes (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic timerTick,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic portOutA,
    input wire logic portOutB,
    input wire logic pinDirectionBitA,
    input wire logic pinDirectionBitB,
    output logic pinOutA,
    output logic pinOutB,
    output logic pinOutEnA_n,
    output logic pinOutEnB_n,
    output logic otherModeSelect
);
    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [2:0] waveformMode_ff;
    logic [1:0] compareOutputModeA_ff;
    logic [1:0] compareOutputModeB_ff;
    logic [7:0] counterValue_ff;
    logic [7:0] compareValueA_ff;
    logic [7:0] compareValueB_ff;
    logic [7:0] compareBufA_ff;
    logic [7:0] compareBufB_ff;
    logic overflowFlag_ff;
    logic compareFlagA_ff;
    logic compareFlagB_ff;
    logic compareOutputStateA_ff;
    logic compareOutputStateB_ff;
    logic blockMatch_ff;
    logic [7:0] nxt_regRdData;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic wrCtrl, wrForce, wrCount, wrCmpA, wrCmpB, wrFlags;
    logic isNormal, isClearOnMatch, isFast, isPwm, waveformModeHighBit;
    logic [7:0] topValue;
    logic atTop, matchA, matchB;
    logic forceA, forceB;

    assign wrCtrl = regWrite && regAddr == tmw_pkg::REG_CTRL;
    assign wrForce = regWrite && regAddr == tmw_pkg::REG_FORCE;
    assign wrCount = regWrite && regAddr == tmw_pkg::REG_COUNT;
    assign wrCmpA = regWrite && regAddr == tmw_pkg::REG_CMPA;
    assign wrCmpB = regWrite && regAddr == tmw_pkg::REG_CMPB;
    assign wrFlags = regWrite && regAddr == tmw_pkg::REG_FLAGS;

    assign isNormal = waveformMode_ff == tmw_pkg::WGM_NORMAL;
    assign isClearOnMatch = waveformMode_ff == tmw_pkg::WGM_CLEAR_ON_MATCH;
    assign isFast = waveformMode_ff == tmw_pkg::WGM_FAST_MAX
        || waveformMode_ff == tmw_pkg::WGM_FAST_CMPA;
    assign isPwm = isFast;
    assign waveformModeHighBit = waveformMode_ff[2];
    assign otherModeSelect = !(isNormal || isClearOnMatch || isFast);

    // top: compare a in mode 2 and 7, max otherwise
    assign topValue = (isClearOnMatch || waveformMode_ff == tmw_pkg::WGM_FAST_CMPA)
        ? compareValueA_ff : tmw_pkg::CNT_MAX;
    assign atTop = counterValue_ff == topValue;

    assign matchA = counterValue_ff == compareValueA_ff && !blockMatch_ff;
    assign matchB = counterValue_ff == compareValueB_ff && !blockMatch_ff;

    assign forceA = wrForce && regWrData[tmw_pkg::FORCE_A_BIT] && !isPwm && !otherModeSelect;
    assign forceB = wrForce && regWrData[tmw_pkg::FORCE_B_BIT] && !isPwm && !otherModeSelect;

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    // mode used from the cycle after the write
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            waveformMode_ff <= tmw_pkg::WGM_NORMAL;
            compareOutputModeA_ff <= tmw_pkg::COM_OFF;
            compareOutputModeB_ff <= tmw_pkg::COM_OFF;
        end else if (wrCtrl) begin
            waveformMode_ff <= regWrData[2:0];
            compareOutputModeA_ff <= regWrData[tmw_pkg::CTRL_MODE_A_LSB +: 2];
            compareOutputModeB_ff <= regWrData[tmw_pkg::CTRL_MODE_B_LSB +: 2];
        end
    end

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    // software write wins over count and clear
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            counterValue_ff <= tmw_pkg::RST_BYTE;
        end else if (wrCount) begin
            counterValue_ff <= regWrData;
        end else if (timerTick && !otherModeSelect) begin
            if ((isClearOnMatch && matchA) || (isFast && atTop)) begin
                counterValue_ff <= tmw_pkg::CNT_BOTTOM;
            end else begin
                counterValue_ff <= counterValue_ff + 8'h01;
            end
        end
    end

    // match blocking holds until the next tick
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            blockMatch_ff <= 1'b0;
        end else if (wrCount) begin
            blockMatch_ff <= 1'b1;
        end else if (timerTick) begin
            blockMatch_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // compare registers
    // ----------------------------------------------------------------
    // buffer in pwm, direct otherwise
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            compareBufA_ff <= tmw_pkg::RST_BYTE;
            compareBufB_ff <= tmw_pkg::RST_BYTE;
        end else begin
            if (wrCmpA) begin
                compareBufA_ff <= regWrData;
            end
            if (wrCmpB) begin
                compareBufB_ff <= regWrData;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            compareValueA_ff <= tmw_pkg::RST_BYTE;
            compareValueB_ff <= tmw_pkg::RST_BYTE;
        end else if (!isPwm) begin
            compareValueA_ff <= wrCmpA ? regWrData : compareValueA_ff;
            compareValueB_ff <= wrCmpB ? regWrData : compareValueB_ff;
        end else if (timerTick && atTop) begin
            compareValueA_ff <= compareBufA_ff;
            compareValueB_ff <= compareBufB_ff;
        end
    end

    // ----------------------------------------------------------------
    // flags
    // ----------------------------------------------------------------
    // overflow set wins over clear
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            overflowFlag_ff <= 1'b0;
        end else if (timerTick && !wrCount && !otherModeSelect
                && ((isFast && atTop)
                || (!isFast && counterValue_ff == tmw_pkg::CNT_MAX))) begin
            overflowFlag_ff <= 1'b1;
        end else if (wrFlags && regWrData[tmw_pkg::FLAG_OVF_BIT]) begin
            overflowFlag_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            compareFlagA_ff <= 1'b0;
            compareFlagB_ff <= 1'b0;
        end else begin
            if (timerTick && matchA && !otherModeSelect) begin
                compareFlagA_ff <= 1'b1;
            end else if (wrFlags && regWrData[tmw_pkg::FLAG_CMPA_BIT]) begin
                compareFlagA_ff <= 1'b0;
            end
            if (timerTick && matchB && !otherModeSelect) begin
                compareFlagB_ff <= 1'b1;
            end else if (wrFlags && regWrData[tmw_pkg::FLAG_CMPB_BIT]) begin
                compareFlagB_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // output-compare states
    // ----------------------------------------------------------------
    // next state from action code on match (non-pwm, or fast pwm)
    function automatic logic nextState(
        input logic cur,
        input logic [1:0] com,
        input logic match,
        input logic force_,
        input logic pwm,
        input logic bottomStep,
        input logic toggleOk,
        input logic cmpIsTop
    );
        logic res;
        res = cur;
        if (!pwm) begin
            if (match || force_) begin
                unique case (com)
                    tmw_pkg::COM_OFF: res = cur;
                    tmw_pkg::COM_TOGGLE: res = !cur;
                    tmw_pkg::COM_CLEAR: res = 1'b0;
                    tmw_pkg::COM_SET: res = 1'b1;
                endcase
            end
        end else begin
            unique case (com)
                tmw_pkg::COM_OFF: res = cur;
                tmw_pkg::COM_TOGGLE: res = (match && toggleOk) ? !cur : cur;
                // match ignored when compare is top
                tmw_pkg::COM_CLEAR: res = bottomStep ? 1'b1 : ((match && !cmpIsTop) ? 1'b0 : cur);
                tmw_pkg::COM_SET: res = bottomStep ? 1'b0 : ((match && !cmpIsTop) ? 1'b1 : cur);
            endcase
        end
        return res;
    endfunction : nextState

    // states update regardless of pin direction
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            compareOutputStateA_ff <= 1'b0;
            compareOutputStateB_ff <= 1'b0;
        end else if (!otherModeSelect) begin
            compareOutputStateA_ff <= nextState(compareOutputStateA_ff,
                compareOutputModeA_ff, timerTick && matchA, forceA, isPwm,
                timerTick && isFast && atTop, waveformModeHighBit,
                compareValueA_ff == topValue);
            compareOutputStateB_ff <= nextState(compareOutputStateB_ff,
                compareOutputModeB_ff, timerTick && matchB, forceB, isPwm,
                timerTick && isFast && atTop, 1'b0,
                compareValueB_ff == topValue);
        end
    end

    // ----------------------------------------------------------------
    // pin override
    // ----------------------------------------------------------------
    // override by mode bits only
    assign pinOutA = (compareOutputModeA_ff != tmw_pkg::COM_OFF)
        ? compareOutputStateA_ff : portOutA;
    assign pinOutB = (compareOutputModeB_ff != tmw_pkg::COM_OFF)
        ? compareOutputStateB_ff : portOutB;
    assign pinOutEnA_n = !pinDirectionBitA;
    assign pinOutEnB_n = !pinDirectionBitB;

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_comb begin
        nxt_regRdData = 8'h00;
        unique case (regAddr)
            tmw_pkg::REG_CTRL: nxt_regRdData = {compareOutputModeA_ff,
                compareOutputModeB_ff, 1'b0, waveformMode_ff};
            tmw_pkg::REG_COUNT: nxt_regRdData = counterValue_ff;
            tmw_pkg::REG_CMPA: nxt_regRdData = isPwm ? compareBufA_ff : compareValueA_ff;
            tmw_pkg::REG_CMPB: nxt_regRdData = isPwm ? compareBufB_ff : compareValueB_ff;
            tmw_pkg::REG_FLAGS: nxt_regRdData = {5'h00, compareFlagB_ff,
                compareFlagA_ff, overflowFlag_ff};
            tmw_pkg::REG_STATE: nxt_regRdData = {6'h00, compareOutputStateA_ff,
                compareOutputStateB_ff};
            default: nxt_regRdData = 8'h00;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            regRdData <= tmw_pkg::RST_BYTE;
        end else begin
            regRdData <= regRead ? nxt_regRdData : 8'h00;
        end
    end
endmodule : tmw_timer8_waveform_modes

// [tmw_timer8_waveform_modes_monitor.sv]
// Purpose: port-level checks for the timer waveform block
// Assumes: control register shadowed from bus writes
// Notes: single clock domain, disabled while sys_rst is high
`timescale 1ns/1ns
module tmw_timer8_waveform_modes_monitor (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic timerTick,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdData,
    input wire logic portOutA,
    input wire logic portOutB,
    input wire logic pinDirectionBitA,
    input wire logic pinDirectionBitB,
    input wire logic pinOutA,
    input wire logic pinOutB,
    input wire logic pinOutEnA_n,
    input wire logic pinOutEnB_n,
    input wire logic otherModeSelect
);
    logic [1:0] modeA_ff;
    logic [1:0] modeB_ff;
    logic [2:0] wave_ff;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // shadow of the control register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            modeA_ff <= 2'h0;
            modeB_ff <= 2'h0;
            wave_ff <= 3'h0;
        end else if (regWrite && regAddr == tmw_pkg::REG_CTRL) begin
            modeA_ff <= regWrData[7:6];
            modeB_ff <= regWrData[5:4];
            wave_ff <= regWrData[2:0];
        end
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    pin_enable_a: assert property ((pinOutEnA_n == !pinDirectionBitA)
        && (pinOutEnB_n == !pinDirectionBitB)) else $error("pin enable differs from direction");
    port_pass_a: assert property (modeA_ff == tmw_pkg::COM_OFF |-> pinOutA == portOutA)
        else $error("pin a not from port");
    port_pass_b: assert property (modeB_ff == tmw_pkg::COM_OFF |-> pinOutB == portOutB)
        else $error("pin b not from port");
    state_pin_a: assert property (regRead && regAddr == tmw_pkg::REG_STATE
        && modeA_ff != 2'h0 |=> regRdData[1] == $past(pinOutA) && regRdData[7:2] == 6'h00)
        else $error("pin a differs from state");
    read_idle_a: assert property (!regRead |=> regRdData == 8'h00)
        else $error("read data outside read slot");
    force_read_a: assert property (regRead && regAddr == tmw_pkg::REG_FORCE
        |=> regRdData == 8'h00) else $error("force register readable");
    other_mode_a: assert property (otherModeSelect == !(wave_ff inside {3'h0, 3'h2, 3'h3,
        3'h7})) else $error("other mode select wrong");
    count_hold_a: assert property (regRead && regAddr == tmw_pkg::REG_COUNT && !timerTick
        ##1 regRead && regAddr == tmw_pkg::REG_COUNT |=> regRdData == $past(regRdData))
        else $error("counter moved without tick");
    cover property (regWrite && regAddr == tmw_pkg::REG_FORCE);
    cover property (otherModeSelect && timerTick);
    cover property (modeA_ff == tmw_pkg::COM_TOGGLE && timerTick);
endmodule : tmw_timer8_waveform_modes_monitor
bind tmw_timer8_waveform_modes tmw_timer8_waveform_modes_monitor tmw_mon_i (.clock(clock),
    .sys_rst(sys_rst), .timerTick(timerTick), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .portOutA(portOutA),
    .portOutB(portOutB), .pinDirectionBitA(pinDirectionBitA),
    .pinDirectionBitB(pinDirectionBitB), .pinOutA(pinOutA), .pinOutB(pinOutB),
    .pinOutEnA_n(pinOutEnA_n), .pinOutEnB_n(pinOutEnB_n), .otherModeSelect(otherModeSelect));

// [tmw_timer8_waveform_modes_tb.sv]
// Purpose: self-checking bench for the timer waveform block
// Assumes: register port with read data one cycle after the strobe
// Notes: expected values come from the counting and output rules
`timescale 1ns/1ns
module tmw_timer8_waveform_modes_tb;
    logic clock, sys_rst, timerTick, regWrite, regRead, portOutA, portOutB;
    logic pinDirectionBitA, pinDirectionBitB, pinOutA, pinOutB, pinOutEnA_n, pinOutEnB_n;
    logic otherModeSelect, padA, padB;
    logic [3:0] regAddr;
    logic [7:0] regWrData, regRdData;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [1:0] comTab [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
    logic expTab [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    tmw_timer8_waveform_modes tmw_timer8_waveform_modes_i (.clock(clock), .sys_rst(sys_rst),
        .timerTick(timerTick), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData), .portOutA(portOutA), .portOutB(portOutB),
        .pinDirectionBitA(pinDirectionBitA), .pinDirectionBitB(pinDirectionBitB),
        .pinOutA(pinOutA), .pinOutB(pinOutB), .pinOutEnA_n(pinOutEnA_n),
        .pinOutEnB_n(pinOutEnB_n), .otherModeSelect(otherModeSelect));
    tmw_port_model tmw_port_model_a_i (.pinOut(pinOutA), .pinOutEn_n(pinOutEnA_n), .padLevel(padA));
    tmw_port_model tmw_port_model_b_i (.pinOut(pinOutB), .pinOutEn_n(pinOutEnB_n), .padLevel(padB));
    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        #1 check(regRdData, exp);
    endtask : rd
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clock);
            timerTick <= 1'b1;
            @(posedge clock);
            timerTick <= 1'b0;
        end
    endtask : tick
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    // free-running clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // limit on the whole run
    initial begin
        #1500000;
        n_mismatch++;
        results();
    end
    // main sequence
    initial begin
        {sys_rst, timerTick, regWrite, regRead, regAddr, regWrData} = {1'b1, 15'h0000};
        {portOutA, portOutB, pinDirectionBitA, pinDirectionBitB} = 4'h0;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00);
        check(padA, 1'b1);
        wr(tmw_pkg::REG_COUNT, 8'hfe);
        tick(2);
        rd(tmw_pkg::REG_COUNT, 8'h00);
        rd(tmw_pkg::REG_FLAGS, 8'h01);
        wr(tmw_pkg::REG_FLAGS, 8'h01);
        rd(tmw_pkg::REG_FLAGS, 8'h00);
        wr(tmw_pkg::REG_CMPB, 8'h05);
        wr(tmw_pkg::REG_COUNT, 8'h03);
        tick(3);
        rd(tmw_pkg::REG_FLAGS, 8'h04);
        wr(tmw_pkg::REG_FLAGS, 8'h04);
        wr(tmw_pkg::REG_COUNT, 8'h05);
        tick(1);
        rd(tmw_pkg::REG_FLAGS, 8'h00);
        rd(tmw_pkg::REG_COUNT, 8'h06);
        // forced actions while the pin is still an input
        for (int i = 0; i < 4; i++) begin
            wr(tmw_pkg::REG_CTRL, {comTab[i], 6'h00});
            wr(tmw_pkg::REG_FORCE, 8'h02);
            rd(tmw_pkg::REG_STATE, {6'h00, expTab[i], 1'b0});
            check(pinOutA, (i < 3) ? expTab[i] : portOutA);
        end
        wr(tmw_pkg::REG_CTRL, 8'h30);
        wr(tmw_pkg::REG_FORCE, 8'h01);
        rd(tmw_pkg::REG_STATE, 8'h03);
        @(posedge clock);
        pinDirectionBitB <= 1'b1;
        @(posedge clock);
        #1 check({pinOutEnB_n, padB, padA}, 8'h03);
        wr(tmw_pkg::REG_CTRL, 8'h42);
        wr(tmw_pkg::REG_CMPA, 8'h03);
        wr(tmw_pkg::REG_COUNT, 8'h00);
        wr(tmw_pkg::REG_FLAGS, 8'h07);
        tick(4);
        rd(tmw_pkg::REG_COUNT, 8'h00);
        rd(tmw_pkg::REG_STATE, 8'h01);
        rd(tmw_pkg::REG_FLAGS, 8'h02);
        // count above compare a wraps through max and sets overflow
        wr(tmw_pkg::REG_FLAGS, 8'h07);
        wr(tmw_pkg::REG_COUNT, 8'hff);
        tick(1);
        rd(tmw_pkg::REG_COUNT, 8'h00);
        rd(tmw_pkg::REG_FLAGS, 8'h01);
        // fast pwm to max, buffered compare
        wr(tmw_pkg::REG_CTRL, 8'h83);
        wr(tmw_pkg::REG_CMPA, 8'h02);
        wr(tmw_pkg::REG_COUNT, 8'hfd);
        wr(tmw_pkg::REG_FLAGS, 8'h07);
        tick(3);
        rd(tmw_pkg::REG_COUNT, 8'h00);
        rd(tmw_pkg::REG_FLAGS, 8'h01);
        rd(tmw_pkg::REG_STATE, 8'h03);
        tick(3);
        rd(tmw_pkg::REG_STATE, 8'h01);
        // no toggle without the high waveform bit
        wr(tmw_pkg::REG_CTRL, 8'h43);
        tick(256);
        rd(tmw_pkg::REG_STATE, 8'h01);
        check(pinOutA, 1'b0);
        // fast pwm with compare a as top
        wr(tmw_pkg::REG_CTRL, 8'h47);
        wr(tmw_pkg::REG_COUNT, 8'h00);
        tick(3);
        rd(tmw_pkg::REG_COUNT, 8'h00);
        rd(tmw_pkg::REG_STATE, 8'h03);
        // other encodings hand over and freeze
        for (int w = 7; w >= 0; w--) begin
            wr(tmw_pkg::REG_CTRL, w[7:0]);
            #1 check(otherModeSelect, !(w inside {0, 2, 3, 7}));
        end
        wr(tmw_pkg::REG_CTRL, 8'h01);
        wr(tmw_pkg::REG_COUNT, 8'h10);
        tick(2);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= tmw_pkg::REG_COUNT;
        repeat (2) @(posedge clock);
        regRead <= 1'b0;
        #1 check(regRdData, 8'h10);
        results();
    end
endmodule : tmw_timer8_waveform_modes_tb
